// ### dv/rf_transceiver_config_regs_tb.sv
// Bench joining the host and transceiver ends over the programming link
`timescale 1ns/1ps
`include "rftc_params.svh"
module rf_transceiver_config_regs_tb import rftc_pkg::*;;
   // ==========================================
   // Stimulus and observed signals
   localparam logic [27:0] SYNC_PAT = 28'h9a5c3e1; // No shifted self-match
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, refused;
   logic rx_bit = 1'b0, rx_bit_valid = 1'b0, seq_tick = 1'b0, lock_detect = 1'b0;
   logic sync_lock, lock_timeout, cal_start, pa_on, rate_invalid, lna_en, filter_en, adc_en, demod_en;
   logic rssi_rb_valid, aux_rb_valid, adc_tx_rb_valid, afc_rb_valid;
   logic [7:0] index_count, deviation_scale;
   logic [6:0] rate_a;
   logic [14:0] rate_divisor;
   int miscompares = 0, n_checks = 0, cal_cnt = 0;
   always #4 pclk = ~pclk;
   // Counts calibration pulses so a doubled pulse shows
   always @(posedge pclk) if (cal_start === 1'b1) cal_cnt <= cal_cnt + 1;
   rftc_if rftc_if_i ();
   rftc_host rftc_host_i (.link(rftc_if_i.host), .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   rftc_device rftc_device_i (.link(rftc_if_i.dev), .pclk, .presetn, .rx_bit, .rx_bit_valid, .seq_tick,
      .lock_detect, .sync_lock, .lock_timeout, .cal_start, .pa_on, .index_count, .rate_a, .rate_invalid,
      .rate_divisor, .deviation_scale, .lna_en, .filter_en, .adc_en, .demod_en, .rssi_rb_valid,
      .aux_rb_valid, .adc_tx_rb_valid, .afc_rb_valid);
   rftc_properties rftc_properties_i (.pclk, .presetn, .serial_clock(rftc_if_i.serial_clock),
      .serial_data_in(rftc_if_i.serial_data_in), .serial_latch_strobe(rftc_if_i.serial_latch_strobe),
      .rx_bit_valid, .sync_lock, .cal_start, .rate_a, .rate_invalid, .index_count, .deviation_scale,
      .lna_en, .filter_en, .adc_en, .demod_en);
   // ==========================================
   // Shared tasks
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   task settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : settle
   // One APB transfer; the request is held until pready is seen
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 50) begin
         chk("pready", 1'b0, 1'b1);
         close_out();
      end
   endtask : apb
   // Sends one link word and polls busy; a refusal is remembered
   task send(input rftc_word_t w);
      int i;
      apb(1'b1, `RFTC_HOST_WORD, w);
      refused = 1'b0;
      for (i = 0; i < 400; i++) begin
         apb(1'b0, `RFTC_HOST_STAT, 32'h0);
         refused = refused | rd[1];
         if (rd[0] === 1'b0) break;
      end
      if (i == 400) begin
         chk("busy", 1'b1, 1'b0);
         close_out();
      end
      settle(4);
   endtask : send
   task rxb(input logic b);
      @(posedge pclk);
      rx_bit <= b;
      rx_bit_valid <= 1'b1;
      @(posedge pclk);
      rx_bit_valid <= 1'b0;
   endtask : rxb
   task tick;
      @(posedge pclk);
      seq_tick <= 1'b1;
      @(posedge pclk);
      seq_tick <= 1'b0;
   endtask : tick
   function automatic rftc_word_t l2(logic m, logic [1:0] ix, logic [2:0] g, logic [6:0] r, logic pa);
      return {2'b00, m, 1'b0, ix, g, r, 8'h00, pa, 3'b000, 4'h2};
   endfunction : l2
   function automatic rftc_word_t l4(logic [2:0] s, logic [8:0] th, logic [1:0] d);
      return {6'h00, s, th, 8'h00, d, 4'h4};
   endfunction : l4
   // ==========================================
   // Scenarios
   task t_regs;
      settle(1);
      chk("index_count", index_count, 8'h10);
      chk("deviation", deviation_scale, 8'h01);
      chk("rate_invalid", rate_invalid, 1'b1);
      apb(1'b0, `RFTC_HOST_DIV, 32'h0);
      chk("div_reset", rd, {16'h0000, `RFTC_HOST_DIV_RST});
      apb(1'b1, `RFTC_HOST_DIV, 32'h6);
      apb(1'b0, `RFTC_HOST_DIV, 32'h0);
      chk("div_write", rd, 32'h6);
      apb(1'b0, 12'h0fc, 32'h0);
      chk("unmapped", err, 1'b1);
      $display("test regs done");
   endtask : t_regs
   task t_txmod;
      int k;
      logic [6:0] r;
      for (k = 0; k < 8; k++) begin
         r = 7'(127 - 18 * k);
         send(l2(1'b0, k[1:0], k[2:0], r, 1'b1));
         chk("index_count", index_count, 8'h10 << k[1:0]);
         chk("rate_a", rate_a, r);
         chk("rate_divisor", rate_divisor, (8'h10 << k[1:0]) * r);
         chk("deviation", deviation_scale, 32'h1 << k[2:0]);
         chk("rate_invalid", rate_invalid, 1'b0);
      end
      send(l2(1'b0, 2'b00, 3'h0, 7'h00, 1'b1));
      chk("zero_refused", refused, 1'b1);
      chk("rate_kept", rate_a, 7'h01);
      send(l2(1'b1, 2'b00, 3'h0, 7'h01, 1'b1));
      chk("pa_muted", pa_on, 1'b0);
      @(posedge pclk);
      lock_detect <= 1'b1;
      settle(3);
      chk("pa_locked", pa_on, 1'b1);
      $display("test txmod done");
   endtask : t_txmod
   task t_power;
      int k;
      int c0;
      for (k = 6; k < 11; k++) begin
         send(32'h8 | (32'h1 << k));
         chk("enables", {demod_en, adc_en, filter_en, lna_en}, (k < 10) ? (32'h1 << (k - 6)) : 32'h0);
      end
      chk("adc_tx_off", adc_tx_rb_valid, 1'b0);
      send(32'h0000_0008);
      chk("adc_tx_on", adc_tx_rb_valid, 1'b1);
      chk("rssi_tx", rssi_rb_valid, 1'b0);
      send(32'h0c00_000e);
      chk("bad_index", index_count, 8'h10);
      c0 = cal_cnt;
      send(32'h0008_0006);
      chk("cal_once", cal_cnt - c0, 1);
      send(32'h0000_0006);
      chk("cal_none", cal_cnt - c0, 1);
      $display("test power done");
   endtask : t_power
   task t_rx;
      int d;
      send(32'h0800_0000);
      chk("rssi_rx", rssi_rb_valid, 1'b1);
      for (d = 3; d >= 0; d--) begin
         send(l4(3'h0, 9'h000, d[1:0]));
         chk("afc_valid", afc_rb_valid, d < 2);
         chk("aux_valid", aux_rb_valid, d != 2);
      end
      send(32'h0004_0009);
      chk("aux_agc", aux_rb_valid, 1'b0);
      send(32'h0000_0009);
      send(l4(`RFTC_SETUP_MODE5, 9'h004, 2'b00));
      repeat (3) tick();
      settle(3);
      chk("timeout_early", lock_timeout, 1'b0);
      tick();
      settle(3);
      chk("timeout_hit", lock_timeout, 1'b1);
      $display("test rx done");
   endtask : t_rx
   task t_sync;
      int s;
      int i;
      send({SYNC_PAT, 4'h5});
      for (s = 0; s < 3; s++) begin
         send(l4((s == 0) ? 3'h0 : 3'(s + 1), 9'h000, 2'b00));
         for (i = 27; i >= 0; i--) rxb(SYNC_PAT[i]);
         settle(2);
         chk("sync_hit", sync_lock, s != 0);
         for (i = 0; i < 8; i++) rxb(1'b0);
         settle(2);
         chk("sync_tail8", sync_lock, s != 0);
         rxb(1'b0);
         settle(2);
         chk("sync_tail9", sync_lock, 1'b0);
      end
      $display("test sync done");
   endtask : t_sync
   // ==========================================
   // Main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_txmod();
      t_power();
      t_rx();
      t_sync();
      close_out();
   end
endmodule : rf_transceiver_config_regs_tb

// ### dv/rftc_properties.sv
// Concurrent checks on the programming link and the transceiver outputs
`timescale 1ns/1ps
module rftc_properties (
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // Link wires
   input logic serial_clock,
   input logic serial_data_in,
   input logic serial_latch_strobe,
   // Receive status
   input logic rx_bit_valid,
   input logic sync_lock,
   input logic cal_start,
   // Transmit settings and enables
   input logic [6:0] rate_a,
   input logic rate_invalid,
   input logic [7:0] index_count,
   input logic [7:0] deviation_scale,
   input logic lna_en,
   input logic filter_en,
   input logic adc_en,
   input logic demod_en
);
   // ==========================================
   // Helper counters
   logic [7:0] since_r; // Cycles since strobe rise, saturating
   logic [5:0] rises_r; // Link clock rises in the current word
   logic [3:0] tail_r;  // Bits received while lock is high
   logic strb_q;        // Strobe one cycle ago
   logic sclk_q;        // Link clock one cycle ago
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Saturating so a stale strobe never looks recent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_r <= 8'hff;
         rises_r <= 6'h00;
         tail_r <= 4'h0;
         strb_q <= 1'b0;
         sclk_q <= 1'b0;
      end else begin
         strb_q <= serial_latch_strobe;
         sclk_q <= serial_clock;
         since_r <= (serial_latch_strobe && !strb_q) ? 8'h00 : ((since_r == 8'hff) ? since_r : since_r + 8'h01);
         rises_r <= (serial_latch_strobe && !strb_q) ? 6'h00 : rises_r + 6'((serial_clock && !sclk_q) ? 1 : 0);
         tail_r <= !sync_lock ? 4'h0 : tail_r + 4'(rx_bit_valid);
      end
   end
   // ==========================================
   // Assertions
   rate_flag_a: assert property ((rate_a != 7'h00) [*2] |-> !rate_invalid)
      else $error("rate flag set for nonzero rate");
   index_code_a: assert property (index_count inside {8'h10, 8'h20, 8'h40, 8'h80})
      else $error("index count outside its four values");
   shaping_pow_a: assert property ($onehot(deviation_scale))
      else $error("deviation scale not a power of two");
   cal_pulse_a: assert property (cal_start |=> !cal_start)
      else $error("calibration start longer than one cycle");
   cal_latch_a: assert property (cal_start |-> since_r inside {[2:10]})
      else $error("calibration start without a latch");
   sync_rise_a: assert property ($rose(sync_lock) |-> $past(rx_bit_valid))
      else $error("sync lock rose without a received bit");
   sync_tail_a: assert property (sync_lock |-> tail_r < 4'd9)
      else $error("sync lock held past nine bits");
   enables_latch_a: assert property (!$stable({lna_en, filter_en, adc_en, demod_en}) |-> since_r inside {[1:10]})
      else $error("block enable changed without a latch");
   word_len_a: assert property ($rose(serial_latch_strobe) |-> rises_r == 6'd32)
      else $error("latched word not 32 bits long");
   strobe_low_a: assert property (serial_latch_strobe |-> !serial_clock)
      else $error("link clock high while strobe high");
   data_hold_a: assert property (serial_clock && $past(serial_clock) |-> $stable(serial_data_in))
      else $error("link data moved while clock high");
endmodule : rftc_properties

// ### hdl/rftc_device.sv
// Transceiver end: serial shift register, eleven latches and the logic they steer
`timescale 1ns/1ps
`include "rftc_params.svh"
// Notes on behaviour
// - Hold 28-bit sync pattern, compare received bits
// - Sync match in receive drives lock high
// - Lock drops after nine more data bits
// - Sync detect only for setup codes 010/011
// - Transmitter sends sync MSB first
// - Writing calibration bit 19 starts filter calibration
// - Host sets filter divider near 50 kHz
// - Index code selects 16, 32, 64, 128
// - Rate divider 1..127, zero invalid
// - Deviation scales as two to shaping value
// - Mute-until-lock keeps amplifier off until lock
// - Power bits enable LNA, filter, ADC, demod
// - Signal strength readback valid only receiving
// - Aux readbacks unavailable receiving with ASK/AGC
// - Transmit ADC readback needs log amp on
// - Frequency readback needs linear or correlator demod
// - Host keeps offset clock 1 to 2 MHz
// - Host keeps demod clock below 12/6 MHz
// - Host keeps recovery clock within 2%
// - Host sets sequencer clock 100/40 kHz
// - Mode 5 lock timeout counts sequencer periods
// - Latch strobe rise transfers shifted word
// - Four low bits choose destination latch
module rftc_device import rftc_pkg::*; #(
   parameter int NREG = `RFTC_NREG,
   parameter int SYNC_W = 28,
   parameter int TAIL_BITS = 9,
   parameter int LOCKTH_W = 9
) (
   // Programming link
   rftc_if.dev link,
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Received data and timing
   input wire logic rx_bit,
   input wire logic rx_bit_valid,
   input wire logic seq_tick,
   input wire logic lock_detect,
   // Receive status
   output logic sync_lock,
   output logic lock_timeout,
   output logic cal_start,
   // Transmit settings
   output logic pa_on,
   output logic [7:0] index_count,
   output logic [6:0] rate_a,
   output logic rate_invalid,
   output logic [14:0] rate_divisor,
   output logic [7:0] deviation_scale,
   // Block enables
   output logic lna_en,
   output logic filter_en,
   output logic adc_en,
   output logic demod_en,
   // Readback validity
   output logic rssi_rb_valid,
   output logic aux_rb_valid,
   output logic adc_tx_rb_valid,
   output logic afc_rb_valid
);
   // ==========================================
   // Link synchronisers
   logic sclk_s1_r, sclk_s2_r, sclk_s3_r; // Shift clock, third flop for edge find
   logic sdat_s1_r, sdat_s2_r;           // Data, two flops, level with the clock's second flop
   logic sle_s1_r, sle_s2_r, sle_s3_r;   // Latch strobe
   // Second and third clock and strobe flops only feed the edge finders below
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= 3'h0;
         {sdat_s1_r, sdat_s2_r} <= 2'h0;
         {sle_s1_r, sle_s2_r, sle_s3_r} <= 3'h0;
      end else begin
         {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= {link.serial_clock, sclk_s1_r, sclk_s2_r};
         {sdat_s1_r, sdat_s2_r} <= {link.serial_data_in, sdat_s1_r};
         {sle_s1_r, sle_s2_r, sle_s3_r} <= {link.serial_latch_strobe, sle_s1_r, sle_s2_r};
      end
   end

   wire sclk_rise = sclk_s2_r & ~sclk_s3_r; // Shift edge
   wire sle_rise = sle_s2_r & ~sle_s3_r;    // Latch edge

   // ==========================================
   // Shift register and latches
   rftc_word_t shift_r;                 // Serial shift register
   rftc_word_t regs_r [0:NREG-1];       // Latched configuration words
   wire [3:0] latch_idx = shift_r[3:0]; // Destination select
   // Indices 11..15 have no latch here and are dropped
   wire latch_hit = sle_rise && (latch_idx < 4'(NREG));

   // Data arrives MSB first, so each bit enters at the bottom
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) shift_r <= '0;
      else if (sclk_rise) shift_r <= {shift_r[30:0], sdat_s2_r};
   end

   // One latch per entry; the whole word moves in a single edge
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_latch
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) regs_r[gi] <= '0;
            else if (latch_hit && latch_idx == 4'(gi)) regs_r[gi] <= shift_r;
         end
      end
   endgenerate

   // ==========================================
   // Field decode
   wire rx_mode = regs_r[`RFTC_IDX_N][`RFTC_R0_RX_BIT];
   wire [31:0] r2 = regs_r[`RFTC_IDX_TXMOD];
   wire [31:0] r4 = regs_r[`RFTC_IDX_DEMOD];
   wire [31:0] r8 = regs_r[`RFTC_IDX_PWR];
   wire [SYNC_W-1:0] sync_pattern = regs_r[`RFTC_IDX_SYNC][`RFTC_R5_SYNC_LSB +: SYNC_W];
   wire [2:0] demod_setup = r4[`RFTC_R4_SETUP_LSB +: 3];
   wire [LOCKTH_W-1:0] lock_threshold = r4[`RFTC_R4_LOCKTH_LSB +: LOCKTH_W];
   wire rftc_dsel_e dsel = rftc_dsel_e'(r4[`RFTC_R4_DSEL_LSB +: 2]);
   wire agc_en = regs_r[`RFTC_IDX_AGC][`RFTC_R9_AGC_EN_BIT];
   wire [1:0] index_code = r2[`RFTC_R2_INDEX_LSB +: 2];
   wire [2:0] gauss_code = r2[`RFTC_R2_GAUSS_LSB +: 3];
   wire [6:0] rate_field = r2[`RFTC_R2_RATE_LSB +: 7];
   wire mute_until_lock = r2[`RFTC_R2_MUTE_BIT];
   wire pa_field = r2[`RFTC_R2_PA_EN_BIT];
   wire sync_en = rx_mode && (demod_setup == `RFTC_SETUP_SYNC_A || demod_setup == `RFTC_SETUP_SYNC_B);
   wire mode5 = rx_mode && (demod_setup == `RFTC_SETUP_MODE5);
   wire r4_written = latch_hit && latch_idx == 4'(`RFTC_IDX_DEMOD);
   // Log amp starts on with transmit; power bit 10 set turns it off
   wire logamp_on = ~r8[`RFTC_R8_LOGAMP_OFF_BIT];
   wire [7:0] index_nxt = `RFTC_INDEX_BASE << index_code;
   wire [7:0] dev_nxt = 8'h01 << gauss_code;
   wire [14:0] div_nxt = 15'(index_nxt) * 15'(rate_field);

   // ==========================================
   // Calibration start pulse
   // A rewrite with the bit still set starts another calibration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cal_start <= 1'b0;
      else cal_start <= latch_hit && latch_idx == 4'(`RFTC_IDX_CORR) && shift_r[`RFTC_R6_CAL_BIT];
   end

   // ==========================================
   // Sync word detector
   logic [SYNC_W-1:0] rx_sr_r; // Last received bits, newest at bottom
   logic [4:0] fill_r;         // Bits seen since detection was enabled
   logic [3:0] tail_r;         // Bits received since lock rose
   wire [SYNC_W-1:0] rx_sr_nxt = {rx_sr_r[SYNC_W-2:0], rx_bit};
   wire sr_full = (fill_r >= 5'(SYNC_W - 1));
   // Comparison uses the word including the bit arriving now
   wire sync_match = rx_bit_valid && sync_en && sr_full && (rx_sr_nxt == sync_pattern);
   wire tail_done = rx_bit_valid && (tail_r == 4'(TAIL_BITS - 1));

   // Receive shift register; only its fill count is cleared when detection is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sr_r <= '0;
         fill_r <= 5'h00;
      end else if (!sync_en) begin
         fill_r <= 5'h00;
      end else if (rx_bit_valid) begin
         rx_sr_r <= rx_sr_nxt;
         if (!sr_full) fill_r <= fill_r + 5'h01;
      end
   end

   // Lock output: rises on a match, falls after the ninth following bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_lock <= 1'b0;
         tail_r <= 4'h0;
      end else if (!sync_en) begin
         sync_lock <= 1'b0; // Leaving receive or the sync modes drops it
         tail_r <= 4'h0;
      end else if (!sync_lock) begin
         if (sync_match) sync_lock <= 1'b1;
         tail_r <= 4'h0;
      end else if (tail_done) begin
         sync_lock <= 1'b0;
      end else if (rx_bit_valid) begin
         tail_r <= tail_r + 4'h1;
      end
   end

   // ==========================================
   // Mode 5 lock timeout
   logic [LOCKTH_W-1:0] lock_cnt_r; // Sequencer periods since mode 5 began
   // A new demodulator word restarts the wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_cnt_r <= '0;
         lock_timeout <= 1'b0;
      end else if (!mode5 || r4_written) begin
         lock_cnt_r <= '0;
         lock_timeout <= 1'b0;
      end else if (lock_cnt_r == lock_threshold) begin
         lock_timeout <= 1'b1;
      end else if (seq_tick) begin
         lock_cnt_r <= lock_cnt_r + 1'b1;
      end
   end

   // ==========================================
   // Registered settings and validity flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pa_on <= 1'b0;
         index_count <= `RFTC_INDEX_BASE;
         rate_a <= 7'h00;
         rate_invalid <= 1'b1;
         rate_divisor <= 15'h0000;
         deviation_scale <= 8'h01;
      end else begin
         pa_on <= pa_field && !(mute_until_lock && !lock_detect);
         index_count <= index_nxt;
         rate_a <= rate_field;
         rate_invalid <= (rate_field == 7'h00);
         rate_divisor <= div_nxt;
         deviation_scale <= dev_nxt;
      end
   end

   // Block enables and readback validity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {lna_en, filter_en, adc_en, demod_en} <= 4'h0;
         {rssi_rb_valid, aux_rb_valid, adc_tx_rb_valid, afc_rb_valid} <= 4'h0;
      end else begin
         lna_en <= r8[`RFTC_R8_LNA_BIT];
         filter_en <= r8[`RFTC_R8_FILT_BIT];
         adc_en <= r8[`RFTC_R8_ADC_BIT];
         demod_en <= r8[`RFTC_R8_DEMOD_BIT];
         rssi_rb_valid <= rx_mode;
         aux_rb_valid <= !(rx_mode && (dsel == DSEL_ASK || agc_en));
         adc_tx_rb_valid <= !rx_mode && logamp_on;
         afc_rb_valid <= rx_mode && (dsel == DSEL_LINEAR || dsel == DSEL_CORR);
      end
   end
endmodule : rftc_device

// ### hdl/rftc_host.sv
// Host end: APB register slave that serialises 32-bit words onto the three-wire link
`timescale 1ns/1ps
`include "rftc_params.svh"
module rftc_host import rftc_pkg::*; (
   // Programming link
   rftc_if.host link,
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ==========================================
   // Register decode
   rftc_host_state_e state_r;   // Serialiser state
   rftc_word_t word_r;          // Last accepted word
   rftc_word_t sh_r;            // Bits still to send
   logic [15:0] div_r;          // Half period of the shift clock in pclk cycles
   logic [15:0] cnt_r;          // Half period counter
   logic [4:0] bit_r;           // Bit being sent
   logic refused_r;             // Sticky: a word was refused
   logic sclk_r, serial_data_in_r, sle_r;
   wire hit_word = (paddr == `RFTC_HOST_WORD);
   wire hit_stat = (paddr == `RFTC_HOST_STAT);
   wire hit_div = (paddr == `RFTC_HOST_DIV);
   wire mapped = hit_word | hit_stat | hit_div;
   wire access = psel & penable;
   wire setup = psel & ~penable;
   wire wr_word = access & pwrite & hit_word;
   wire wr_div = access & pwrite & hit_div;
   wire busy = (state_r != H_IDLE);
   // A transmit-modulation word with a zero rate divider is never sent
   wire bad_rate = (pwdata[3:0] == 4'(`RFTC_IDX_TXMOD)) && (pwdata[`RFTC_R2_RATE_LSB +: 7] == 7'h00);
   wire start = wr_word & ~busy & ~bad_rate;
   wire refuse = wr_word & (busy | bad_rate);
   wire [15:0] div_eff = (div_r == 16'h0000) ? 16'h0001 : div_r;
   wire half_done = (cnt_r == div_eff - 16'h0001);
   wire [31:0] rd_mux = hit_word ? word_r :
                        hit_stat ? {30'h0, refused_r, busy} :
                        hit_div ? {16'h0, div_r} : 32'h0;

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign link.serial_clock = sclk_r;
   assign link.serial_data_in = serial_data_in_r;
   assign link.serial_latch_strobe = sle_r;

   // ==========================================
   // APB registers; read data is captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         div_r <= `RFTC_HOST_DIV_RST;
         refused_r <= 1'b0;
      end else begin
         if (setup & ~pwrite) prdata <= rd_mux;
         if (wr_div) div_r <= pwdata[15:0];
         // Setting wins over a status read that would clear it
         if (refuse) refused_r <= 1'b1;
         else if (access & ~pwrite & hit_stat) refused_r <= 1'b0;
      end
   end

   // ==========================================
   // Serialiser: data changes while the clock is low, MSB first
   // Divider fields in words are software's choice, except that a zero rate divider is refused
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= H_IDLE;
         word_r <= '0;
         sh_r <= '0;
         cnt_r <= 16'h0000;
         bit_r <= 5'h00;
         {sclk_r, serial_data_in_r, sle_r} <= 3'h0;
      end else begin
         case (state_r)
            H_IDLE: begin
               if (start) begin
                  word_r <= pwdata;
                  sh_r <= pwdata;
                  serial_data_in_r <= pwdata[31];
                  cnt_r <= 16'h0000;
                  bit_r <= 5'h00;
                  state_r <= H_LOW;
               end
            end
            H_LOW: begin
               if (half_done) begin
                  sclk_r <= 1'b1;
                  cnt_r <= 16'h0000;
                  state_r <= H_HIGH;
               end else cnt_r <= cnt_r + 16'h0001;
            end
            H_HIGH: begin
               if (half_done) begin
                  sclk_r <= 1'b0;
                  cnt_r <= 16'h0000;
                  if (bit_r == 5'h1f) begin
                     sle_r <= 1'b1; // Word complete, latch it
                     state_r <= H_LATCH;
                  end else begin
                     bit_r <= bit_r + 5'h01;
                     sh_r <= {sh_r[30:0], 1'b0};
                     serial_data_in_r <= sh_r[30];
                     state_r <= H_LOW;
                  end
               end else cnt_r <= cnt_r + 16'h0001;
            end
            H_LATCH: begin
               if (half_done) begin
                  sle_r <= 1'b0;
                  cnt_r <= 16'h0000;
                  state_r <= H_GAP;
               end else cnt_r <= cnt_r + 16'h0001;
            end
            H_GAP: begin
               // Idle gap so the device sees the strobe fall before the next word
               if (half_done) begin
                  cnt_r <= 16'h0000;
                  state_r <= H_IDLE;
               end else cnt_r <= cnt_r + 16'h0001;
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end
endmodule : rftc_host

// ### hdl/rftc_if.sv
// Three-wire programming link between host and transceiver
`timescale 1ns/1ps
interface rftc_if;
   // ==========================================
   // Link wires, all driven by the host
   logic serial_clock;        // Shift clock
   logic serial_data_in;      // Data, MSB first
   logic serial_latch_strobe; // Rising edge latches the word
   modport dev (input serial_clock, input serial_data_in, input serial_latch_strobe);
   modport host (output serial_clock, output serial_data_in, output serial_latch_strobe);
endinterface : rftc_if

// ### hdl/rftc_params.svh
// Offsets, field positions, reset values and timing counts of the transceiver config port
`ifndef RFTC_PARAMS_SVH
`define RFTC_PARAMS_SVH
// ==========================================
// Latch indices (four low control bits)
`define RFTC_NREG 11
`define RFTC_IDX_N 0
`define RFTC_IDX_TXMOD 2
`define RFTC_IDX_DEMOD 4
`define RFTC_IDX_SYNC 5
`define RFTC_IDX_CORR 6
`define RFTC_IDX_RDBK 7
`define RFTC_IDX_PWR 8
`define RFTC_IDX_AGC 9
// ==========================================
// Field positions
`define RFTC_R0_RX_BIT 27
`define RFTC_R2_PA_EN_BIT 7
`define RFTC_R2_RATE_LSB 16
`define RFTC_R2_GAUSS_LSB 23
`define RFTC_R2_INDEX_LSB 26
`define RFTC_R2_MUTE_BIT 29
`define RFTC_R4_DSEL_LSB 4
`define RFTC_R4_LOCKTH_LSB 14
`define RFTC_R4_SETUP_LSB 23
`define RFTC_R5_SYNC_LSB 4
`define RFTC_R6_CAL_BIT 19
`define RFTC_R8_LNA_BIT 6
`define RFTC_R8_FILT_BIT 7
`define RFTC_R8_ADC_BIT 8
`define RFTC_R8_DEMOD_BIT 9
`define RFTC_R8_LOGAMP_OFF_BIT 10
`define RFTC_R9_AGC_EN_BIT 18
// ==========================================
// Demodulator setup codes and index count base
`define RFTC_SETUP_SYNC_A 3'h2
`define RFTC_SETUP_SYNC_B 3'h3
`define RFTC_SETUP_MODE5 3'h5
`define RFTC_INDEX_BASE 8'h10
// ==========================================
// Host register map (APB byte offsets) and reset values
`define RFTC_HOST_WORD 12'h000
`define RFTC_HOST_STAT 12'h004
`define RFTC_HOST_DIV 12'h008
`define RFTC_HOST_DIV_RST 16'h0005
`endif

// ### hdl/rftc_pkg.sv
// Types shared by both ends of the transceiver config port
package rftc_pkg;
   // ==========================================
   // Host serialiser states
   typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_LATCH, H_GAP} rftc_host_state_e;
   // Demodulator select field
   typedef enum logic [1:0] {DSEL_LINEAR, DSEL_CORR, DSEL_ASK, DSEL_OTHER} rftc_dsel_e;
   typedef logic [31:0] rftc_word_t;
endpackage : rftc_pkg
